/* hw/cbt_can_timing.sv */
// Implementation choices: the placing of the registers and the plain strobed port.
`include "cbt_regs.svh"

module cbt_can_timing
  import cbt_pkg::*;
#(
  parameter int unsigned NUM_OBJ = 15
) (
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire logic [7:0]     addr_i,
  input  wire logic [7:0]     wdata_i,
  input  wire logic           wr_i,
  input  wire logic           rd_i,
  output logic [7:0]          rdata_o,
  input  wire logic           ctrl_enabled_i,
  input  wire logic [14:0]    object_irq_src_i,
  input  wire logic [15:0]    ttc_value_i,
  input  wire logic [7:0]     tx_error_count_i,
  input  wire logic           rx_bit_i,
  output logic                object_irq_o,
  output logic [3:0]          top_priority_object_o,
  output logic                timer_overrun_o,
  output logic                timer_overrun_flag_o,
  output logic [15:0]         timer_count_o,
  output cbt_timing_t         timing_o,
  output cbt_seg_t            segment_o,
  output cbt_bit_event_t      bit_event_o
);

  if (NUM_OBJ < 1 || NUM_OBJ > 15) begin : g_bad_obj
    $error("cbt_can_timing: NUM_OBJ must be 1 to 15");
  end

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire wr_ie_lo  = wr_i && (addr_i == `CBT_OFS_IE_LOW);
  wire wr_ie_hi  = wr_i && (addr_i == `CBT_OFS_IE_HIGH);
  wire wr_bt1    = wr_i && (addr_i == `CBT_OFS_BT_PRESC);
  wire wr_bt2    = wr_i && (addr_i == `CBT_OFS_BT_JUMP);
  wire wr_bt3    = wr_i && (addr_i == `CBT_OFS_BT_PHASE);
  wire wr_tpr    = wr_i && (addr_i == `CBT_OFS_TIM_PRESC);
  wire wr_flags  = wr_i && (addr_i == `CBT_OFS_TIM_FLAGS);

  logic [15:0]     ie_q;
  logic [15:0]     sit_q;
  cbt_timing_t     cfg_q;
  logic [7:0]      tpr_q;
  logic [15:0]     timer_q;
  logic            ovr_q;
  logic [15:0]     ttc_q;
  logic [7:0]      tec_q;
  logic [7:0]      rdata_q;

  wire [15:0] obj_mask = 16'((17'h1 << NUM_OBJ) - 17'h1);
  wire [15:0] ie_d     = {wr_ie_hi ? (wdata_i & `CBT_IE_HIGH_MASK) : ie_q[15:8],
                          wr_ie_lo ? wdata_i : ie_q[7:0]};
  wire [7:0]  bt1_d    = wdata_i & `CBT_BT1_MASK;
  wire [7:0]  bt2_d    = wdata_i & `CBT_BT2_MASK;
  wire [7:0]  bt3_d    = wdata_i & `CBT_BT3_MASK;

  // Enable bits: bit 15 and unused objects never stored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ie_q <= 16'h0000;
    end else begin
      ie_q <= ie_d & obj_mask;
    end
  end

  // Pending vector: gated object sources, read-only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sit_q <= 16'h0000;
    end else begin
      sit_q <= {1'b0, object_irq_src_i} & ie_q & obj_mask;
    end
  end

  // Bit timing configuration
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= '0;
    end else begin
      if (wr_bt1) begin
        cfg_q.baud_prescaler <= bt1_d[6:1];
      end
      if (wr_bt2) begin
        cfg_q.resync_jump_width   <= bt2_d[6:5];
        cfg_q.propagation_segment <= bt2_d[3:1];
      end
      if (wr_bt3) begin
        cfg_q.phase_segment_two    <= bt3_d[6:4];
        cfg_q.phase_segment_one    <= bt3_d[3:1];
        cfg_q.triple_sample_select <= bt3_d[0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tpr_q <= `CBT_TIM_PRESC_RST;
    end else if (wr_tpr) begin
      tpr_q <= wdata_i;
    end
  end

  // TTC timer and error count mirror the controller core
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ttc_q <= 16'h0000;
      tec_q <= 8'h00;
    end else begin
      ttc_q <= ttc_value_i;
      tec_q <= tx_error_count_i;
    end
  end

  // ----------------------------------------
  // CAN timer
  // ----------------------------------------
  logic timer_tick;

  cbt_divider #(
    .W (11)
  ) u_timer_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .en_i    (ctrl_enabled_i),
    .term_i  ({tpr_q, 3'h7}),
    .tick_o  (timer_tick)
  );

  wire timer_wrap = timer_tick && (timer_q == `CBT_TIMER_MAX);
  wire ovr_clear  = wr_flags && wdata_i[`CBT_OVR_BIT];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_q <= 16'h0000;
    end else if (timer_tick) begin
      timer_q <= 16'(timer_q + 16'h0001);
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_q <= 1'b0;
    end else begin
      ovr_q <= timer_wrap || (ovr_q && !ovr_clear);
    end
  end

  // ----------------------------------------
  // Highest-priority object
  // ----------------------------------------
  function automatic logic [3:0] cbt_top_obj(input logic [15:0] v);
    logic [3:0] r;
    r = `CBT_TOP_OBJ_NONE;
    for (int i = 14; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : cbt_top_obj

  wire [3:0] top_obj = cbt_top_obj(sit_q);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    unique case (addr_i)
      `CBT_OFS_IE_LOW:    rd_mux = ie_q[7:0];
      `CBT_OFS_IE_HIGH:   rd_mux = ie_q[15:8];
      `CBT_OFS_SIT_LOW:   rd_mux = sit_q[7:0];
      `CBT_OFS_SIT_HIGH:  rd_mux = sit_q[15:8];
      `CBT_OFS_BT_PRESC:  rd_mux = {1'b0, cfg_q.baud_prescaler, 1'b0};
      `CBT_OFS_BT_JUMP:   rd_mux = {1'b0, cfg_q.resync_jump_width, 1'b0,
                                    cfg_q.propagation_segment, 1'b0};
      `CBT_OFS_BT_PHASE:  rd_mux = {1'b0, cfg_q.phase_segment_two,
                                    cfg_q.phase_segment_one, cfg_q.triple_sample_select};
      `CBT_OFS_TIM_PRESC: rd_mux = tpr_q;
      `CBT_OFS_TIM_LOW:   rd_mux = timer_q[7:0];
      `CBT_OFS_TIM_HIGH:  rd_mux = timer_q[15:8];
      `CBT_OFS_TTC_LOW:   rd_mux = ttc_q[7:0];
      `CBT_OFS_TTC_HIGH:  rd_mux = ttc_q[15:8];
      `CBT_OFS_TX_ERR:    rd_mux = tec_q;
      `CBT_OFS_TOP_OBJ:   rd_mux = {top_obj, 4'h0};
      `CBT_OFS_TIM_FLAGS: rd_mux = {7'h00, ovr_q};
      default:            rd_mux = 8'h00;
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Bit timing engine
  // ----------------------------------------
  logic       q_tick;
  cbt_seg_t   seg_q;
  cbt_seg_t   seg_d;
  logic [3:0] qcnt_q;
  logic [3:0] elapsed_q;
  logic [2:0] extend_q;
  logic [2:0] shorten_q;
  logic       resynced_q;
  logic       rx_prev_q;
  logic [1:0] rx_hist_q;
  logic       bit_value_q;
  logic       sample_q;
  logic       start_q;

  cbt_divider #(
    .W (6)
  ) u_quantum_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .en_i    (ctrl_enabled_i),
    .term_i  (cfg_q.baud_prescaler),
    .tick_o  (q_tick)
  );

  wire [2:0] sjw_len  = 3'({1'b0, cfg_q.resync_jump_width} + 3'h1);
  wire [3:0] prop_len = 4'({1'b0, cfg_q.propagation_segment} + 4'h1);
  wire [3:0] ph1_base = 4'({1'b0, cfg_q.phase_segment_one} + 4'h1);
  wire [3:0] ph2_base = 4'({1'b0, cfg_q.phase_segment_two} + 4'h1);

  // Falling edge seen across one quantum, once per bit
  wire edge_fall = q_tick && rx_prev_q && !rx_bit_i && !resynced_q;
  wire in_late   = (seg_q == CBT_SEG_PROP) || (seg_q == CBT_SEG_PHASE1);
  wire late_edge = edge_fall && in_late;
  wire early_edg = edge_fall && (seg_q == CBT_SEG_PHASE2);

  wire [3:0] phase_err = 4'(elapsed_q + 4'h1);
  wire [2:0] ext_now   = (phase_err > 4'(sjw_len)) ? sjw_len : phase_err[2:0];
  wire [2:0] ext_eff   = late_edge ? ext_now : extend_q;
  wire [3:0] ph2_left  = 4'(ph2_base - qcnt_q - 4'h1);
  wire       restart   = early_edg && (ph2_left <= 4'(sjw_len));
  wire [2:0] shr_eff   = (early_edg && !restart) ? sjw_len : shorten_q;
  wire [3:0] ph1_len   = 4'(ph1_base + 4'(ext_eff));
  wire [3:0] ph2_len   = 4'(ph2_base - 4'(shr_eff));

  logic [3:0] seg_len;
  always_comb begin
    unique case (seg_q)
      CBT_SEG_SYNC:   seg_len = 4'h1;
      CBT_SEG_PROP:   seg_len = prop_len;
      CBT_SEG_PHASE1: seg_len = ph1_len;
      CBT_SEG_PHASE2: seg_len = ph2_len;
    endcase
  end

  wire seg_last   = (qcnt_q == 4'(seg_len - 4'h1));
  wire sample_now = q_tick && (seg_q == CBT_SEG_PHASE1) && seg_last;
  wire enter_sync = q_tick && (seg_q == CBT_SEG_PHASE2) && seg_last && !restart;
  wire new_bit    = enter_sync || (q_tick && restart);

  always_comb begin
    unique case (seg_q)
      CBT_SEG_SYNC:   seg_d = CBT_SEG_PROP;
      CBT_SEG_PROP:   seg_d = CBT_SEG_PHASE1;
      CBT_SEG_PHASE1: seg_d = CBT_SEG_PHASE2;
      CBT_SEG_PHASE2: seg_d = CBT_SEG_SYNC;
    endcase
  end

  // Majority of the samples two and one clocks before and at the point
  wire vote   = (rx_hist_q[1] & rx_hist_q[0]) | (rx_hist_q[1] & rx_bit_i) |
                (rx_hist_q[0] & rx_bit_i);
  wire smp_in = cfg_q.triple_sample_select ? vote : rx_bit_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_q  <= CBT_SEG_SYNC;
      qcnt_q <= 4'h0;
    end else if (!ctrl_enabled_i) begin
      seg_q  <= CBT_SEG_SYNC;
      qcnt_q <= 4'h0;
    end else if (q_tick && restart) begin
      seg_q  <= CBT_SEG_PROP;
      qcnt_q <= 4'h0;
    end else if (q_tick && seg_last) begin
      seg_q  <= seg_d;
      qcnt_q <= 4'h0;
    end else if (q_tick) begin
      qcnt_q <= 4'(qcnt_q + 4'h1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      elapsed_q <= 4'h0;
    end else if (!ctrl_enabled_i || new_bit || (q_tick && seg_q == CBT_SEG_SYNC)) begin
      elapsed_q <= 4'h0;
    end else if (q_tick && in_late) begin
      elapsed_q <= 4'(elapsed_q + 4'h1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      extend_q   <= 3'h0;
      shorten_q  <= 3'h0;
      resynced_q <= 1'b0;
    end else if (!ctrl_enabled_i || new_bit) begin
      extend_q   <= 3'h0;
      shorten_q  <= 3'h0;
      resynced_q <= 1'b0;
    end else if (late_edge) begin
      extend_q   <= ext_now;
      resynced_q <= 1'b1;
    end else if (early_edg) begin
      shorten_q  <= sjw_len;
      resynced_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_prev_q <= 1'b1;
      rx_hist_q <= 2'h3;
    end else begin
      rx_hist_q <= {rx_hist_q[0], rx_bit_i};
      if (q_tick) begin
        rx_prev_q <= rx_bit_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_value_q <= 1'b1;
      sample_q    <= 1'b0;
      start_q     <= 1'b0;
    end else begin
      sample_q <= sample_now;
      start_q  <= new_bit;
      if (sample_now) begin
        bit_value_q <= smp_in;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o               = rdata_q;
  assign object_irq_o          = |sit_q;
  assign top_priority_object_o = top_obj;
  assign timer_overrun_o       = timer_wrap;
  assign timer_overrun_flag_o  = ovr_q;
  assign timer_count_o         = timer_q;
  assign timing_o              = cfg_q;
  assign segment_o             = seg_q;
  assign bit_event_o           = '{bit_start: start_q, sample: sample_q, value: bit_value_q};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_ie_low_store: assert property (wr_ie_lo |=> ie_q[7:0] == $past(wdata_i))
    else $error("enable low byte not stored");
  a_sit_masked: assert property ((sit_q & ~$past(ie_q)) == 16'h0000)
    else $error("pending bit set for masked object");
  a_top_none: assert property ((sit_q == 16'h0000) |-> top_priority_object_o == 4'hF)
    else $error("top object not all ones when idle");
  a_top_pending: assert property ((sit_q != 16'h0000) |-> sit_q[top_priority_object_o])
    else $error("top object not pending");
  a_ovr_set: assert property (timer_wrap |=> ovr_q && timer_q == 16'h0000)
    else $error("overrun flag or wrap missing");
  a_timer_still: assert property (!timer_tick |=> $stable(timer_q))
    else $error("timer moved without tick");
  a_timer_gated: assert property (!ctrl_enabled_i |-> !timer_tick && !q_tick)
    else $error("tick while controller disabled");
  a_tick_period: assert property ((timer_tick && tpr_q == 8'h00 && !wr_tpr) |=>
                                  !timer_tick [*7] ##1 (timer_tick || !ctrl_enabled_i))
    else $error("timer tick period wrong");
  a_unmapped_zero: assert property ((rd_i && addr_i > 8'h0E) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_single_sample: assert property ((sample_now && !cfg_q.triple_sample_select) |=>
                                    bit_value_q == $past(rx_bit_i))
    else $error("single sample wrong");
  a_triple_vote: assert property ((sample_now && cfg_q.triple_sample_select) |=>
                                  bit_value_q == $past(vote))
    else $error("triple sample vote wrong");
  a_jump_limit: assert property ((extend_q <= sjw_len) && (shorten_q <= sjw_len))
    else $error("resync beyond jump width");

  c_overrun: cover property (timer_wrap);
  c_late_resync: cover property (late_edge);
  c_early_restart: cover property (q_tick && restart);
  c_triple: cover property (sample_now && cfg_q.triple_sample_select);

endmodule : cbt_can_timing

/* hw/cbt_divider.sv */
module cbt_divider #(
  parameter int unsigned W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] term_i,
  output logic              tick_o
);

  if (W < 1 || W > 16) begin : g_bad_width
    $error("cbt_divider: W must be 1 to 16");
  end

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // Tick on the last clock of each period of term_i+1 clocks
  assign tick_o  = en_i && (count_q >= term_i);
  assign count_d = (!en_i || tick_o) ? '0 : W'(count_q + 1'b1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : cbt_divider

/* hw/cbt_pkg.sv */
package cbt_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [5:0] baud_prescaler;
    logic [1:0] resync_jump_width;
    logic [2:0] propagation_segment;
    logic [2:0] phase_segment_two;
    logic [2:0] phase_segment_one;
    logic       triple_sample_select;
  } cbt_timing_t;

  typedef enum logic [1:0] {
    CBT_SEG_SYNC  = 2'b00,
    CBT_SEG_PROP  = 2'b01,
    CBT_SEG_PHASE1 = 2'b10,
    CBT_SEG_PHASE2 = 2'b11
  } cbt_seg_t;

  typedef struct packed {
    logic bit_start;
    logic sample;
    logic value;
  } cbt_bit_event_t;

endpackage : cbt_pkg

/* hw/cbt_regs.svh */
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CBT_OFS_IE_LOW     8'h00
`define CBT_OFS_IE_HIGH    8'h01
`define CBT_OFS_SIT_LOW    8'h02
`define CBT_OFS_SIT_HIGH   8'h03
`define CBT_OFS_BT_PRESC   8'h04
`define CBT_OFS_BT_JUMP    8'h05
`define CBT_OFS_BT_PHASE   8'h06
`define CBT_OFS_TIM_PRESC  8'h07
`define CBT_OFS_TIM_LOW    8'h08
`define CBT_OFS_TIM_HIGH   8'h09
`define CBT_OFS_TTC_LOW    8'h0A
`define CBT_OFS_TTC_HIGH   8'h0B
`define CBT_OFS_TX_ERR     8'h0C
`define CBT_OFS_TOP_OBJ    8'h0D
`define CBT_OFS_TIM_FLAGS  8'h0E

// ----------------------------------------
// Field positions and write masks
// ----------------------------------------
`define CBT_IE_HIGH_MASK   8'h7F
`define CBT_BT1_MASK       8'h7E
`define CBT_BT2_MASK       8'h6E
`define CBT_BT3_MASK       8'h7F
`define CBT_OVR_BIT        0

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CBT_BT_RESET       8'h00
`define CBT_TIM_PRESC_RST  8'h00
`define CBT_TIMER_MAX      16'hFFFF
`define CBT_TOP_OBJ_NONE   4'hF

`endif

/* tb/cbt_bus_node.sv */
// ----------------------------------------
// Remote node on the bus, idle recessive
// ----------------------------------------
module cbt_bus_node #(
  parameter int unsigned BIT_CLKS = 12
) (
  input  wire logic clk_i,
  output logic      rx_o,
  output logic      busy_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rx_o   = 1'b1;
    busy_o = 1'b0;
  end

  // Sends one byte MSB first, then releases to recessive
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    busy_o <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      rx_o <= b[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    rx_o   <= 1'b1;
    busy_o <= 1'b0;
  endtask : send
endmodule : cbt_bus_node

/* tb/testbench.sv */
module testbench import cbt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  logic           clk_i = 1'b0;
  logic           rst_n_i = 1'b0;
  logic [7:0]     addr_i = 8'h00;
  logic [7:0]     wdata_i = 8'h00;
  logic           wr_i = 1'b0;
  logic           rd_i = 1'b0;
  logic           ctrl_enabled_i = 1'b0;
  logic [14:0]    object_irq_src_i = 15'h0000;
  logic [15:0]    ttc_value_i = 16'h0000;
  logic [7:0]     tx_error_count_i = 8'h00;
  logic           rx_bit_i;
  logic           busy;
  logic [7:0]     rdata_o;
  logic           object_irq_o;
  logic [3:0]     top_priority_object_o;
  logic [15:0]    timer_count_o;
  cbt_timing_t    timing_o;
  cbt_seg_t       segment_o;
  cbt_bit_event_t bit_event_o;
  logic           timer_overrun_flag_o;
  logic           ovr_pulse;
  int             n_ovr = 0;
  logic [7:0]     d;
  logic [7:0]     cap;
  int             ncap;
  int             n;
  int             n_mismatch = 0;
  int             checked = 0;

  always #50 clk_i = ~clk_i;

  cbt_can_timing u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ctrl_enabled_i(ctrl_enabled_i),
    .object_irq_src_i(object_irq_src_i), .ttc_value_i(ttc_value_i),
    .tx_error_count_i(tx_error_count_i), .rx_bit_i(rx_bit_i), .object_irq_o(object_irq_o),
    .top_priority_object_o(top_priority_object_o), .timer_overrun_o(ovr_pulse),
    .timer_overrun_flag_o(timer_overrun_flag_o), .timer_count_o(timer_count_o),
    .timing_o(timing_o), .segment_o(segment_o), .bit_event_o(bit_event_o)
  );

  cbt_bus_node u_node (.clk_i(clk_i), .rx_o(rx_bit_i), .busy_o(busy));

  // Bit samples taken while the remote node sends
  always @(posedge clk_i) begin
    if (bit_event_o.sample === 1'b1 && busy) begin
      cap  <= {cap[6:0], bit_event_o.value};
      ncap <= ncap + 1;
    end
  end

  // Overrun pulses seen over the whole run
  always @(posedge clk_i) begin
    if (ovr_pulse === 1'b1) begin
      n_ovr <= n_ovr + 1;
    end
  end

  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_start(output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (bit_event_o.bit_start !== 1'b1 && k < 100);
  endtask : wait_start

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(top_priority_object_o, 4'hF);
    chk(timer_overrun_flag_o, 1'b0);
    chk(segment_o, CBT_SEG_SYNC);
    for (int a = 0; a <= 8'h0E; a++) begin
      rd(a[7:0], d);
      chk(d, (a == 8'h0D) ? 8'hF0 : 8'h00);
    end
    rd(8'h20, d);
    chk(d, 8'h00);
  endtask : t_reset

  task automatic t_irq;
    wr(8'h00, 8'h08);
    wr(8'h01, 8'h7F);
    object_irq_src_i <= 15'h0209;
    repeat (2) @(posedge clk_i);
    rd(8'h00, d);
    chk(d, 8'h08);
    rd(8'h01, d);
    chk(d, 8'h7F);
    rd(8'h02, d);
    chk(d, 8'h08);
    rd(8'h03, d);
    chk(d, 8'h02);
    rd(8'h0D, d);
    chk(d, 8'h30);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'hFF);
    repeat (2) @(posedge clk_i);
    rd(8'h02, d);
    chk(d, 8'h00);
    chk(top_priority_object_o, 4'h9);
    chk(object_irq_o, 1'b1);
    object_irq_src_i <= 15'h0000;
    repeat (2) @(posedge clk_i);
    chk(top_priority_object_o, 4'hF);
  endtask : t_irq

  task automatic t_mirror;
    ttc_value_i      <= 16'hA55A;
    tx_error_count_i <= 8'hFF;
    wr(8'h0C, 8'h00);
    wr(8'h0A, 8'h11);
    rd(8'h0A, d);
    chk(d, 8'h5A);
    rd(8'h0B, d);
    chk(d, 8'hA5);
    rd(8'h0C, d);
    chk(d, 8'hFF);
  endtask : t_mirror

  task automatic t_timer;
    wr(8'h07, 8'h01);
    @(posedge clk_i);
    ctrl_enabled_i <= 1'b1;
    repeat (88) @(posedge clk_i);
    ctrl_enabled_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    rd(8'h08, d);
    chk(d, 8'h05);
    rd(8'h09, d);
    chk(d, 8'h00);
    rd(8'h07, d);
    chk(d, 8'h01);
    wr(8'h07, 8'h00);
    @(posedge clk_i);
    ctrl_enabled_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    ctrl_enabled_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(timer_count_o, 16'h000A);
    chk(n_ovr, 0);
    chk(timer_overrun_flag_o, 1'b0);
  endtask : t_timer

  task automatic t_bits;
    cbt_timing_t exp;
    for (int s = 0; s < 2; s++) begin
      wr(8'h04, 8'h02);
      wr(8'h05, 8'h00);
      wr(8'h06, 8'h12 | s[7:0]);
      rd(8'h06, d);
      chk(d, 8'h12 | s[7:0]);
      exp = '{6'd1, 2'd0, 3'd0, 3'd1, 3'd1, s[0]};
      chk(timing_o, exp);
      @(posedge clk_i);
      ctrl_enabled_i <= 1'b1;
      wait_start(n);
      wait_start(n);
      chk(n, 12);
      ncap = 0;
      u_node.send(8'h5A);
      repeat (24) @(posedge clk_i);
      chk(ncap, 8);
      chk(cap, 8'h5A);
      ctrl_enabled_i <= 1'b0;
    end
  endtask : t_bits

  task automatic summarize;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  initial begin
    #(100 * 5000);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    t_reset();
    t_irq();
    t_mirror();
    t_timer();
    t_bits();
    summarize();
  end
endmodule : testbench
